// ==== rtl/cap_report_pkg.sv ====
// capability report fields: shared constants, types and decode helpers
//
// Contract
// - clean request answered by response type 0x96
// - flag bit 0 shows hardware arbitration support
// - flag bit 1 only if driver status supported
// - flag bit 2 only if inbound flow control
// - flag bit 3 only if outbound flow control
// - flag bit 4 marks all-multicast plus global commands
// - bits 6:5 arbitration status, never 11b
// - flag bit 7 only with thermal self-shutdown
// - flag bit 8 only with delayed response
// - broadcast mask mirrors broadcast filter setting bits
// - multicast mask mirrors multicast filter setting bits
// - buffering field gives inbound storage in bytes
// - zero buffering means unspecified, not absent
// - notification support word uses enable word layout
package cap_report_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command and response codes
  localparam logic [7:0]  CMD_GET_CAP      = 8'h16;
  localparam logic [7:0]  RSP_GET_CAP      = 8'h96;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] OFS_FLAGS        = 12'h000;
  localparam logic [11:0] OFS_BCAST        = 12'h004;
  localparam logic [11:0] OFS_MCAST        = 12'h008;
  localparam logic [11:0] OFS_BUFFER       = 12'h00C;
  localparam logic [11:0] OFS_AEN          = 12'h010;
  localparam logic [11:0] OFS_CTRL         = 12'h014;
  localparam logic [11:0] OFS_STATUS       = 12'h018;

  ////////////////////////////////////////////////////////////////////////////
  // capabilities flag word field positions
  localparam int          FLG_HW_ARB       = 0;
  localparam int          FLG_DRV_STATUS   = 1;
  localparam int          FLG_FC_TO_MC     = 2;
  localparam int          FLG_FC_FROM_MC   = 3;
  localparam int          FLG_ALL_MCAST    = 4;
  localparam int          FLG_ARB_LO       = 5;
  localparam int          FLG_ARB_HI       = 6;
  localparam int          FLG_THERMAL      = 7;
  localparam int          FLG_DELAYED      = 8;
  localparam int          FLG_RSVD_LO      = 9;

  // arbitration implementation status codes
  localparam logic [1:0]  ARB_UNKNOWN      = 2'b00;
  localparam logic [1:0]  ARB_NOT_IMPL     = 2'b01;
  localparam logic [1:0]  ARB_IMPL         = 2'b10;
  localparam logic [1:0]  ARB_RSVD         = 2'b11;

  ////////////////////////////////////////////////////////////////////////////
  // control and status field positions
  localparam int          CTRL_ENABLE      = 0;
  localparam int          CTRL_CLR_DROP    = 1;
  localparam int          STAT_CNT_LSB     = 0;
  localparam int          STAT_CNT_MSB     = 15;
  localparam int          STAT_BUSY        = 16;
  localparam int          STAT_DROP        = 17;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [31:0] RST_WORD         = 32'h0000_0000;
  localparam logic        RST_ENABLE       = 1'b1;
  localparam logic [15:0] RST_COUNT        = 16'h0000;
  localparam logic [7:0]  RST_CODE         = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [31:0] flags;   // capabilities flag word
    logic [31:0] bcast;   // broadcast filter capability mask
    logic [31:0] mcast;   // multicast filter capability mask
    logic [31:0] buffer;  // buffering capacity in bytes
    logic [31:0] aen;     // notification-control support word
  } cap_payload_s;

  typedef struct packed {
    logic        en;      // one-cycle write strobe
    logic [11:0] addr;    // byte offset of the word
    logic [31:0] data;    // write data
  } reg_wr_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,     // waiting for a request
    ST_BUILD = 2'b01      // snapshot taken, answer on the way
  } resp_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // word address match, used by read and write decode
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    return a[11:2] == ofs[11:2];
  endfunction : addr_hit

endpackage : cap_report_pkg

// ==== rtl/cap_flag_pack.sv ====
// capability flag word sanitiser
`timescale 1ns/1ps
module cap_flag_pack
  import cap_report_pkg::*;
(
  // raw word from software
  input  wire logic [31:0] raw_flags,
  // word safe to report
  output logic      [31:0] clean_flags
);

  // arbitration status with the reserved code folded away
  logic [1:0] arb_status;

  // reserved 11b is reported as unknown
  always_comb begin
    if (raw_flags[FLG_ARB_HI:FLG_ARB_LO] == ARB_RSVD) begin
      arb_status = ARB_UNKNOWN;
    end else begin
      arb_status = raw_flags[FLG_ARB_HI:FLG_ARB_LO];
    end
  end

  // single-bit capabilities pass, reserved bits forced low
  always_comb begin
    clean_flags                        = RST_WORD;
    clean_flags[FLG_HW_ARB]            = raw_flags[FLG_HW_ARB];
    clean_flags[FLG_DRV_STATUS]        = raw_flags[FLG_DRV_STATUS];
    clean_flags[FLG_FC_TO_MC]          = raw_flags[FLG_FC_TO_MC];
    clean_flags[FLG_FC_FROM_MC]        = raw_flags[FLG_FC_FROM_MC];
    clean_flags[FLG_ALL_MCAST]         = raw_flags[FLG_ALL_MCAST];
    clean_flags[FLG_ARB_HI:FLG_ARB_LO] = arb_status;
    clean_flags[FLG_THERMAL]           = raw_flags[FLG_THERMAL];
    clean_flags[FLG_DELAYED]           = raw_flags[FLG_DELAYED];
  end

endmodule : cap_flag_pack

// ==== rtl/cap_ahb_port.sv ====
// ahb-lite slave front end: zero wait states, always okay
`timescale 1ns/1ps
module cap_ahb_port
  import cap_report_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // ahb-lite slave side
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // register file side
  output logic      [11:0] rd_addr,
  input  wire logic [31:0] rd_data,
  output reg_wr_s          wr
);

  // pending write from the address phase
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [11:0] wr_addr_r;
  logic [11:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        access;

  // valid transfer: selected, nonseq or seq, bus ready
  always_comb begin
    access      = hsel & htrans[1] & hready;
    rd_addr     = haddr;
    wr_pend_nxt = access & hwrite;
    wr_addr_nxt = access ? haddr : wr_addr_r;
    hrdata_nxt  = (access & ~hwrite) ? rd_data : RST_WORD;
    // write strobe lands in the data phase with hwdata
    wr.en       = wr_pend_r;
    wr.addr     = wr_addr_r;
    wr.data     = hwdata;
  end

  // address phase capture
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= OFS_FLAGS;
      hrdata_r  <= RST_WORD;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  // never stalls, never errors
  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : cap_ahb_port

// ==== rtl/cap_report_fields.sv ====
// capability report builder: config registers and discovery responder
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module cap_report_fields
  import cap_report_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // ahb-lite register bus
  input  wire logic         hsel,
  input  wire logic [11:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic         hready,
  input  wire logic [31:0]  hwdata,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // decoded command from the sideband controller
  input  wire logic         cmd_valid,
  input  wire logic [7:0]   cmd_code,
  input  wire logic         cmd_err,
  output logic              cmd_busy,
  // response toward the packet builder
  output logic              rsp_valid,
  output logic      [7:0]   rsp_code,
  output cap_payload_s      rsp_payload
);

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  // zero wait states: every transfer takes one address and one data cycle
  // read data is captured at the address edge and shown for one cycle
  // writes land at the edge that ends their data phase
  // hsize is ignored; every register is one aligned word
  // hreadyout and hresp are constants, so the bus never stalls or errors
  // the port module owns the only flops on the bus path

  logic [11:0]  rd_addr;      // address-phase read offset
  logic [31:0]  rd_data;      // word handed back for the data phase
  reg_wr_s      wr;           // data-phase write strobe
  logic [31:0]  hrdata_w;     // registered read data
  logic         hreadyout_w;  // constant ready
  logic         hresp_w;      // constant okay

  cap_ahb_port u_port (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hrdata    (hrdata_w),
    .hreadyout (hreadyout_w),
    .hresp     (hresp_w),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr        (wr)
  );

  // bus answers all come from flip-flops or constants
  assign hrdata    = hrdata_w;
  assign hreadyout = hreadyout_w;
  assign hresp     = hresp_w;

  ////////////////////////////////////////////////////////////////////////////
  // flag word sanitising on the write path
  // reserved bits and the reserved arbitration code never get stored

  logic [31:0] clean_flags;   // written word with reserved parts cleared

  cap_flag_pack u_pack (
    .raw_flags   (wr.data),
    .clean_flags (clean_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  // software fills these once the capabilities of the channel are known
  // all five words reset to zero, so an unconfigured channel claims nothing
  // buffering zero stands for unspecified, not for no buffer at all
  // the flag word is cleaned on its way in, never on its way out

  logic [31:0] flags_r;       // capabilities flag word
  logic [31:0] flags_nxt;
  logic [31:0] bcast_r;       // broadcast filter capability mask
  logic [31:0] bcast_nxt;
  logic [31:0] mcast_r;       // multicast filter capability mask
  logic [31:0] mcast_nxt;
  logic [31:0] buffer_r;      // inbound storage in bytes
  logic [31:0] buffer_nxt;
  logic [31:0] aen_r;         // notification-control support word
  logic [31:0] aen_nxt;
  logic        enable_r;      // responder on
  logic        enable_nxt;
  logic        clr_drop;      // one-cycle clear of the drop flag

  // write decode; only one word matches per strobe
  always_comb begin
    flags_nxt  = flags_r;
    bcast_nxt  = bcast_r;
    mcast_nxt  = mcast_r;
    buffer_nxt = buffer_r;
    aen_nxt    = aen_r;
    enable_nxt = enable_r;
    clr_drop   = 1'b0;
    if (wr.en) begin
      if (addr_hit(wr.addr, OFS_FLAGS)) begin
        // reserved code and bits never reach the register
        flags_nxt = clean_flags;
      end else if (addr_hit(wr.addr, OFS_BCAST)) begin
        // same positions as the broadcast filter settings
        bcast_nxt = wr.data;
      end else if (addr_hit(wr.addr, OFS_MCAST)) begin
        // same positions as the multicast filter settings
        mcast_nxt = wr.data;
      end else if (addr_hit(wr.addr, OFS_BUFFER)) begin
        // byte count; zero is kept as unspecified
        buffer_nxt = wr.data;
      end else if (addr_hit(wr.addr, OFS_AEN)) begin
        // same layout as the notification enable word
        aen_nxt = wr.data;
      end else if (addr_hit(wr.addr, OFS_CTRL)) begin
        // enable is stored; the clear bit only pulses for one cycle
        enable_nxt = wr.data[CTRL_ENABLE];
        clr_drop   = wr.data[CTRL_CLR_DROP];
      end else begin
        // status and unmapped words ignore writes
        enable_nxt = enable_r;
      end
    end
  end

  // written only through the bus; the responder reads but never writes
  // configuration storage; buffering resets to zero, meaning unspecified
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r  <= RST_WORD;
      bcast_r  <= RST_WORD;
      mcast_r  <= RST_WORD;
      buffer_r <= RST_WORD;
      aen_r    <= RST_WORD;
      enable_r <= RST_ENABLE;
    end else begin
      flags_r  <= flags_nxt;
      bcast_r  <= bcast_nxt;
      mcast_r  <= mcast_nxt;
      buffer_r <= buffer_nxt;
      aen_r    <= aen_nxt;
      enable_r <= enable_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // responder state machine
  // timing of one discovery exchange:
  //   edge 1: clean request taken, fields frozen, busy raised
  //   edge 2: answer strobe and type code out, busy dropped, count bumped
  //   edge 3: answer strobe low again; type code and fields hold
  // a second request at edge 2 is lost and marks the drop flag
  // a request at edge 3 is taken, so the best rate is one per two cycles
  // errored, foreign or disabled requests are ignored without a trace
  // the snapshot protects the answer from a write landing meanwhile

  resp_state_e  state_r;      // responder state
  resp_state_e  state_nxt;
  logic         accept;       // clean discovery request taken now
  logic         busy_hit;     // request arriving while an answer is pending
  logic         drop_r;       // sticky: a request was lost while busy
  logic         drop_nxt;
  logic [15:0]  count_r;      // answers sent, wraps
  logic [15:0]  count_nxt;
  logic         rsp_valid_r;  // one-cycle answer strobe
  logic         rsp_valid_nxt;
  logic [7:0]   rsp_code_r;   // answer type
  logic [7:0]   rsp_code_nxt;
  cap_payload_s payload_r;    // snapshot of the fields
  cap_payload_s payload_nxt;
  logic         busy_r;       // request side held off
  logic         busy_nxt;

  // a request taken while disabled is not queued; the requester must retry
  // request qualification: right code, no error, responder on
  always_comb begin
    accept   = cmd_valid & ~cmd_err & (cmd_code == CMD_GET_CAP) & enable_r & (state_r == ST_IDLE);
    busy_hit = cmd_valid & ~cmd_err & (cmd_code == CMD_GET_CAP) & enable_r & (state_r != ST_IDLE);
  end

  // the count wraps at its width; software reads it as a free running tally
  // next state, snapshot and answer
  always_comb begin
    state_nxt     = state_r;
    payload_nxt   = payload_r;
    rsp_code_nxt  = rsp_code_r;
    rsp_valid_nxt = 1'b0;
    count_nxt     = count_r;
    busy_nxt      = busy_r;
    // a loss in the clearing cycle keeps the flag set
    drop_nxt      = busy_hit | (drop_r & ~clr_drop);
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          // fields frozen so a later write cannot tear the answer
          payload_nxt.flags  = flags_r;
          payload_nxt.bcast  = bcast_r;
          payload_nxt.mcast  = mcast_r;
          payload_nxt.buffer = buffer_r;
          payload_nxt.aen    = aen_r;
          busy_nxt           = 1'b1;
          state_nxt          = ST_BUILD;
        end
      end
      ST_BUILD: begin
        // answer goes out with its type code
        rsp_code_nxt  = RSP_GET_CAP;
        rsp_valid_nxt = 1'b1;
        count_nxt     = count_r + 16'h0001;
        busy_nxt      = 1'b0;
        state_nxt     = ST_IDLE;
      end
      default: begin
        // unused code falls back to idle
        busy_nxt  = 1'b0;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // the code and fields keep their last value between answers
  // responder registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r     <= ST_IDLE;
      payload_r   <= '0;
      rsp_code_r  <= RST_CODE;
      rsp_valid_r <= 1'b0;
      count_r     <= RST_COUNT;
      drop_r      <= 1'b0;
      busy_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      payload_r   <= payload_nxt;
      rsp_code_r  <= rsp_code_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      count_r     <= count_nxt;
      drop_r      <= drop_nxt;
      busy_r      <= busy_nxt;
    end
  end

  // no logic between these flops and the pins
  // answer ports straight from flops
  assign rsp_valid   = rsp_valid_r;
  assign rsp_code    = rsp_code_r;
  assign rsp_payload = payload_r;
  assign cmd_busy    = busy_r;

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  // reads have no side effects; the drop flag clears only by a control write
  // status and control words are rebuilt every cycle from live state
  // unmapped offsets read zero and ignore writes

  logic [31:0] status_word;   // live responder status
  logic [31:0] ctrl_word;     // control readback

  // status and control layout
  always_comb begin
    status_word                            = RST_WORD;
    status_word[STAT_CNT_MSB:STAT_CNT_LSB] = count_r;
    status_word[STAT_BUSY]                 = busy_r;
    status_word[STAT_DROP]                 = drop_r;
    ctrl_word                              = RST_WORD;
    ctrl_word[CTRL_ENABLE]                 = enable_r;
  end

  // address decode mirrors the write side, in the same order
  // read mux; unmapped words read zero
  always_comb begin
    if (addr_hit(rd_addr, OFS_FLAGS)) begin
      rd_data = flags_r;
    end else if (addr_hit(rd_addr, OFS_BCAST)) begin
      rd_data = bcast_r;
    end else if (addr_hit(rd_addr, OFS_MCAST)) begin
      rd_data = mcast_r;
    end else if (addr_hit(rd_addr, OFS_BUFFER)) begin
      rd_data = buffer_r;
    end else if (addr_hit(rd_addr, OFS_AEN)) begin
      rd_data = aen_r;
    end else if (addr_hit(rd_addr, OFS_CTRL)) begin
      rd_data = ctrl_word;
    end else if (addr_hit(rd_addr, OFS_STATUS)) begin
      rd_data = status_word;
    end else begin
      rd_data = RST_WORD;
    end
  end

endmodule : cap_report_fields

// ==== tb/cap_report_properties.sv ====
// concurrent checks on the discovery responder ports
`timescale 1ns/1ps
module cap_report_properties
  import cap_report_pkg::*;
(
  // clock and reset
  input wire logic         clock,
  input wire logic         sys_rst,
  // command side
  input wire logic         cmd_valid,
  input wire logic [7:0]   cmd_code,
  input wire logic         cmd_err,
  input wire logic         cmd_busy,
  // response side
  input wire logic         rsp_valid,
  input wire logic [7:0]   rsp_code,
  input wire cap_payload_s rsp_payload
);
  // one domain: shared clock and reset for all checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // accept-to-answer timing
  property p_busy_then_rsp;
    cmd_busy |=> rsp_valid;
  endproperty
  a_busy_then_rsp: assert property (p_busy_then_rsp) else $error("no answer one cycle after busy");
  property p_rsp_after_busy;
    rsp_valid |-> $past(cmd_busy);
  endproperty
  a_rsp_after_busy: assert property (p_rsp_after_busy) else $error("answer without accept");
  property p_busy_one;
    cmd_busy |=> !cmd_busy;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy longer than one cycle");
  // answer code and refusals
  property p_rsp_code;
    rsp_valid |-> rsp_code == RSP_GET_CAP;
  endproperty
  a_rsp_code: assert property (p_rsp_code) else $error("wrong response code");
  property p_wrong_code;
    cmd_valid && cmd_code != CMD_GET_CAP |=> !cmd_busy;
  endproperty
  a_wrong_code: assert property (p_wrong_code) else $error("other command accepted");
  property p_err;
    cmd_valid && cmd_err |=> !cmd_busy;
  endproperty
  a_err: assert property (p_err) else $error("errored command accepted");
  // reported flag word contents
  property p_rsvd;
    rsp_valid |-> rsp_payload.flags[31:9] == 23'h00_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag bits set");
  property p_arb;
    rsp_valid |-> rsp_payload.flags[6:5] != ARB_RSVD;
  endproperty
  a_arb: assert property (p_arb) else $error("reserved arbitration code");
  // payload only moves at an accept
  property p_payload_hold;
    $changed(rsp_payload) |-> cmd_busy;
  endproperty
  a_payload_hold: assert property (p_payload_hold) else $error("payload changed without accept");

  // main scenarios reached
  c_answer: cover property (rsp_valid);
  c_drop: cover property (cmd_valid && cmd_busy);
  c_err: cover property (cmd_valid && cmd_err);
endmodule : cap_report_properties

// ==== tb/mc_model.sv ====
// management controller model: issues discovery commands, times answers
`timescale 1ns/1ps
module mc_model
  import cap_report_pkg::*;
(
  // clock
  input  wire logic       clock,
  // answer from the channel
  input  wire logic       rsp_valid,
  // command toward the channel
  output logic            cmd_valid,
  output logic      [7:0] cmd_code,
  output logic            cmd_err
);
  // idle lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    cmd_err   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe a command n cycles, give first answer edge (0 = none in 6)
  task automatic req(input logic [7:0] code, input logic err, input int n, output int lat);
    lat = 0;
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_err   <= err;
    for (int k = 1; k <= 6; k++) begin
      @(posedge clock);
      // released lines must not keep the old value
      if (k == n) begin
        cmd_valid <= 1'b0;
        cmd_code  <= ~code;
        cmd_err   <= ~err;
      end
      if (rsp_valid && lat == 0) begin
        lat = k;
      end
    end
  endtask : req
endmodule : mc_model

// ==== tb/capability_report_fields_test.sv ====
// self-checking bench for the capability report block
`timescale 1ns/1ps
module capability_report_fields_test
  import cap_report_pkg::*;
;
  logic         clock;       // 200 MHz
  logic         sys_rst;     // async, high
  logic         hsel;        // bus master side
  logic [11:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;   // also fed back as hready
  logic         hresp;
  logic         cmd_valid;   // from the model
  logic [7:0]   cmd_code;
  logic         cmd_err;
  logic         cmd_busy;
  logic         rsp_valid;
  logic [7:0]   rsp_code;
  cap_payload_s rsp_payload;
  int           bad_count;
  int           n_compared;
  int           lat;         // answer edge from the model
  int           cnt;         // expected answer count
  logic [31:0]  rd;

  cap_report_fields DUT (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_err(cmd_err),
    .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_payload(rsp_payload));
  mc_model mc (.clock(clock), .rsp_valid(rsp_valid), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_err(cmd_err));

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus and verdict tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_pay(input cap_payload_s e);
    chk(rsp_payload.flags, e.flags);
    chk(rsp_payload.bcast, e.bcast);
    chk(rsp_payload.mcast, e.mcast);
    chk(rsp_payload.buffer, e.buffer);
    chk(rsp_payload.aen, e.aen);
  endtask : chk_pay
  // single word transfer, entered just after an edge
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
    chk({30'h0000_0000, hreadyout, hresp}, 32'h0000_0002);
  endtask : rdchk
  task automatic conclude();
    $display("compared %0d, wrong %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #(5000 * 5);
    bad_count++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {sys_rst, hsize} = 4'b1_010;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    {bad_count, n_compared, cnt} = '0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    // reset values, two unmapped words at the end
    for (int i = 0; i < 9; i++) begin
      rdchk(12'(i * 4), i == 5 ? 32'h0000_0001 : 32'h0000_0000);
    end
    // each flag bit alone, reserved ones dropped
    for (int i = 0; i < 32; i++) begin
      wr(OFS_FLAGS, 32'h0000_0001 << i);
      rdchk(OFS_FLAGS, i < 9 ? 32'h0000_0001 << i : 32'h0000_0000);
    end
    wr(OFS_BCAST, 32'hA5A5_0F0F);
    wr(OFS_MCAST, 32'h0000_00FF);
    wr(OFS_AEN, 32'h0000_0007);
    // every arbitration code, buffer zero first
    for (int k = 0; k < 4; k++) begin
      wr(OFS_FLAGS, 32'hFFFF_FF9F | (32'(k) << 5));
      wr(OFS_BUFFER, 32'(k) << 12);
      mc.req(CMD_GET_CAP, 1'b0, 1, lat);
      cnt++;
      chk(32'(lat), 32'h0000_0003);
      chk({24'h00_0000, rsp_code}, {24'h00_0000, RSP_GET_CAP});
      chk_pay({32'h0000_019F | (k == 3 ? 32'h0000_0000 : 32'(k) << 5), 32'hA5A5_0F0F, 32'h0000_00FF,
               32'(k) << 12, 32'h0000_0007});
    end
    // other code, errored request, disabled channel: no answer
    for (int j = 0; j < 3; j++) begin
      wr(OFS_CTRL, j == 2 ? 32'h0000_0000 : 32'h0000_0001);
      mc.req(j == 0 ? 8'h17 : CMD_GET_CAP, j == 1, 1, lat);
      chk(32'(lat), 32'h0000_0000);
    end
    wr(OFS_CTRL, 32'h0000_0001);
    rdchk(OFS_STATUS, 32'(cnt));
    // request while busy is dropped, next one accepted
    mc.req(CMD_GET_CAP, 1'b0, 3, lat);
    cnt += 2;
    chk(32'(lat), 32'h0000_0003);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rdchk(OFS_STATUS, 32'h0002_0000 | 32'(cnt));
    wr(OFS_CTRL, 32'h0000_0003);
    rdchk(OFS_CTRL, 32'h0000_0001);
    rdchk(OFS_STATUS, 32'(cnt));
    // second reset in mid-run
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk({24'h00_0000, rsp_code}, 32'h0000_0000);
    rdchk(OFS_FLAGS, 32'h0000_0000);
    rdchk(OFS_CTRL, 32'h0000_0001);
    conclude();
  end
endmodule : capability_report_fields_test

// checker on the top module ports
bind cap_report_fields cap_report_properties u_props (.clock, .sys_rst, .cmd_valid, .cmd_code, .cmd_err,
  .cmd_busy, .rsp_valid, .rsp_code, .rsp_payload);
